// *** verilog/jai_map.vh ***
// Offsets, field positions, reset values and encodings for the jump and increment executor
`ifndef JAI_MAP_VH
`define JAI_MAP_VH

// APB register offsets (byte addresses)
`define JAI_OFS_CTRL        12'h000
`define JAI_OFS_WACC        12'h004
`define JAI_OFS_FLAGS       12'h008
`define JAI_OFS_PC          12'h00C
`define JAI_OFS_INDEX       12'h010
`define JAI_OFS_EXEC        12'h014
`define JAI_OFS_IREG        12'h018

// Control register fields
`define JAI_CTRL_EXT_BIT    0
`define JAI_CTRL_BANK_LSB   8
`define JAI_CTRL_BANK_MSB   11

// Flag register bit positions
`define JAI_FLAG_C          0
`define JAI_FLAG_HALF       1
`define JAI_FLAG_Z          2
`define JAI_FLAG_EXCESS     3
`define JAI_FLAG_N          4

// Reset values
`define JAI_RST_BANK        4'h0
`define JAI_RST_WACC        8'h00
`define JAI_RST_FLAGS       5'h00
`define JAI_RST_PC          21'h000000
`define JAI_RST_INDEX       12'h000

// Encodings
`define JAI_OP_JUMP1        8'hEF
`define JAI_OP_JUMP2        4'hF
`define JAI_OP_INC_FILE     6'h0A
`define JAI_OP_INCSZ        6'h0F
`define JAI_OP_INCSNZ       6'h12
`define JAI_NOP_WORD        16'h0000
`define JAI_IDX_LIMIT       8'h5F
`define JAI_ACC_SPLIT       8'h60
`define JAI_ACC_HIGH_BANK   4'hF
`define JAI_ACC_LOW_BANK    4'h0
`define JAI_PC_STEP         21'h000002

// Instruction-cycle phases
`define JAI_Q_DECODE        2'h0
`define JAI_Q_READ          2'h1
`define JAI_Q_PROCESS       2'h2
`define JAI_Q_WRITE         2'h3

`endif

// *** verilog/jai_phase.v ***
// Four-phase sequencer dividing core_clk into instruction cycles
`timescale 1ns/1ps
`include "jai_map.vh"

module jai_phase (
  input  wire       core_clk,
  input  wire       rst,
  output reg  [1:0] phase,
  output wire       cycle_end
);

  assign cycle_end = (phase == `JAI_Q_WRITE);

  always @(posedge core_clk) begin
    if (rst) begin
      phase <= `JAI_Q_DECODE;
    end else begin
      phase <= phase + 2'h1;
    end
  end

endmodule // jai_phase

// *** verilog/jai_incr.v ***
// Registered 8-bit incrementer with arithmetic flag results
`timescale 1ns/1ps
`include "jai_map.vh"

module jai_incr (
  input  wire       core_clk,
  input  wire       rst,
  input  wire       load,
  input  wire [7:0] operand,
  output reg  [7:0] sum,
  output reg        carry,
  output reg        half_carry_flag,
  output reg        arithmetic_excess_flag,
  output wire       zero,
  output wire       negative
);

  wire [8:0] wide_sum;

  assign wide_sum = {1'b0, operand} + 9'h001;
  assign zero     = (sum == 8'h00);
  assign negative = sum[7];

  always @(posedge core_clk) begin
    if (rst) begin
      sum                    <= 8'h00;
      carry                  <= 1'b0;
      half_carry_flag        <= 1'b0;
      arithmetic_excess_flag <= 1'b0;
    end else if (load) begin
      sum                    <= wide_sum[7:0];
      carry                  <= wide_sum[8];
      half_carry_flag        <= (operand[3:0] == 4'hF);
      // Only 7Fh crosses into the negative range on an increment
      arithmetic_excess_flag <= (operand == 8'h7F);
    end
  end

endmodule // jai_incr

// *** verilog/jai_exec.v ***
// Decode and execute for absolute jump and the three increment instructions
`timescale 1ns/1ps
`include "jai_map.vh"

module jai_exec #(
  parameter COUNT_W = 8
) (
  input  wire        core_clk,
  input  wire        rst,
  input  wire [11:0] paddr,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  input  wire [15:0] instr_word,
  input  wire [15:0] instr_next,
  output reg  [20:0] pc,
  output reg         fetch_flush,
  output wire [1:0]  cycle_phase,
  output reg  [11:0] dmem_addr,
  output reg         dmem_rd,
  input  wire [7:0]  dmem_rdata,
  output reg         dmem_wr,
  output wire [7:0]  dmem_wdata
);

  localparam ST_RUN   = 2'h0;
  localparam ST_FLUSH = 2'h1;

  reg  [1:0]         state;
  reg  [1:0]         flush_left;
  reg  [15:0]        ir;
  reg                ext_enable;
  reg  [3:0]         bank_select_register;
  reg  [7:0]         wacc;
  reg  [4:0]         flags;
  reg  [11:0]        index_base;
  reg  [1:0]         last_cycles;
  reg                last_skip;
  reg                last_jump;
  reg  [COUNT_W-1:0] retired;
  reg  [31:0]        next_rdata;

  wire [1:0]  phase;
  wire        cycle_end;
  wire [7:0]  inc_sum;
  wire        inc_carry;
  wire        inc_half;
  wire        inc_excess;
  wire        inc_zero;
  wire        inc_neg;
  wire        exec_inc;
  wire        exec_plain;
  wire        exec_sz;
  wire        exec_snz;
  wire        exec_jump;
  wire        dest_reg;
  wire        skip_taken;
  wire        skip_two;
  wire        apb_setup;
  wire        apb_access;
  wire        apb_write;
  wire [20:0] jump_target;

  // Incrementing opcode families share one decode
  function is_inc_op;
    input [15:0] w;
    begin
      is_inc_op = (w[15:10] == `JAI_OP_INC_FILE) || (w[15:10] == `JAI_OP_INCSZ) ||
                  (w[15:10] == `JAI_OP_INCSNZ);
    end
  endfunction

  // Leading words of the instructions that occupy two program words
  function is_two_word;
    input [15:0] w;
    begin
      is_two_word = (w[15:12] == 4'hC) || (w[15:9] == 7'h76) ||
                    (w[15:8] == `JAI_OP_JUMP1) || (w[15:6] == 10'h3B8);
    end
  endfunction

  function [11:0] form_addr;
    input        acc;
    input [7:0]  f;
    input [3:0]  bank;
    input        ext;
    input [11:0] base;
    begin
      if (!acc && ext && (f <= `JAI_IDX_LIMIT)) begin
        form_addr = base + {4'h0, f};
      end else if (!acc) begin
        // Access bank: low bytes of bank 0, upper bytes of the top bank
        form_addr = (f < `JAI_ACC_SPLIT) ? {`JAI_ACC_LOW_BANK, f}
                                         : {`JAI_ACC_HIGH_BANK, f};
      end else begin
        form_addr = {bank, f};
      end
    end
  endfunction

  function addr_hit;
    input [11:0] a;
    begin
      addr_hit = (a == `JAI_OFS_CTRL) || (a == `JAI_OFS_WACC) ||
                 (a == `JAI_OFS_FLAGS) || (a == `JAI_OFS_PC) ||
                 (a == `JAI_OFS_INDEX) || (a == `JAI_OFS_EXEC) ||
                 (a == `JAI_OFS_IREG);
    end
  endfunction

  jai_phase u_phase (
    .core_clk  (core_clk),
    .rst       (rst),
    .phase     (phase),
    .cycle_end (cycle_end)
  );

  jai_incr u_incr (
    .core_clk               (core_clk),
    .rst                    (rst),
    .load                   (exec_inc && (phase == `JAI_Q_PROCESS)),
    .operand                (dmem_rdata),
    .sum                    (inc_sum),
    .carry                  (inc_carry),
    .half_carry_flag        (inc_half),
    .arithmetic_excess_flag (inc_excess),
    .zero                   (inc_zero),
    .negative               (inc_neg)
  );

  assign cycle_phase = phase;
  assign dmem_wdata  = inc_sum;

  // Flush cycles load a no-op word, and decode of ir is also gated by state == ST_RUN
  assign exec_inc   = (state == ST_RUN) && is_inc_op(ir);
  assign exec_plain = exec_inc && (ir[15:10] == `JAI_OP_INC_FILE);
  assign exec_sz    = exec_inc && (ir[15:10] == `JAI_OP_INCSZ);
  assign exec_snz   = exec_inc && (ir[15:10] == `JAI_OP_INCSNZ);
  assign exec_jump  = (state == ST_RUN) && (ir[15:8] == `JAI_OP_JUMP1);
  assign dest_reg   = ir[9];

  assign skip_taken = (exec_sz && inc_zero) || (exec_snz && !inc_zero);
  assign skip_two   = is_two_word(instr_next);

  // Second word must carry its marker nibble; otherwise target bits come from it anyway
  assign jump_target = {instr_next[11:0], ir[7:0], 1'b0};

  assign apb_setup  = psel && !penable;
  assign apb_access = psel && penable;
  assign apb_write  = apb_access && pwrite && addr_hit(paddr) && (paddr != `JAI_OFS_PC) &&
                      (paddr != `JAI_OFS_EXEC) && (paddr != `JAI_OFS_IREG);

  // Zero wait states: every access completes in its first access cycle
  assign pready  = 1'b1;
  assign pslverr = apb_access && (!addr_hit(paddr) ||
                   (pwrite && ((paddr == `JAI_OFS_PC) || (paddr == `JAI_OFS_EXEC) ||
                               (paddr == `JAI_OFS_IREG))));

  always @* begin
    next_rdata = 32'h00000000;
    case (paddr)
      `JAI_OFS_CTRL: begin
        next_rdata[`JAI_CTRL_EXT_BIT]                      = ext_enable;
        next_rdata[`JAI_CTRL_BANK_MSB:`JAI_CTRL_BANK_LSB] = bank_select_register;
      end
      `JAI_OFS_WACC: begin
        next_rdata[7:0] = wacc;
      end
      `JAI_OFS_FLAGS: begin
        next_rdata[4:0] = flags;
      end
      `JAI_OFS_PC: begin
        next_rdata[20:0] = pc;
      end
      `JAI_OFS_INDEX: begin
        next_rdata[11:0] = index_base;
      end
      `JAI_OFS_EXEC: begin
        next_rdata[1:0]            = last_cycles;
        next_rdata[2]              = last_skip;
        next_rdata[3]              = last_jump;
        next_rdata[5:4]            = state;
        next_rdata[7:6]            = flush_left;
        next_rdata[8+COUNT_W-1:8]  = retired;
      end
      `JAI_OFS_IREG: begin
        next_rdata[15:0] = ir;
      end
      default: begin
        next_rdata = 32'h00000000;
      end
    endcase
  end

  // Read data is captured in the setup cycle so it stands through the access cycle
  always @(posedge core_clk) begin
    if (rst) begin
      prdata <= 32'h00000000;
    end else if (apb_setup && !pwrite) begin
      prdata <= next_rdata;
    end
  end

  // Software-visible state; execution writes take priority in the same edge
  always @(posedge core_clk) begin
    if (rst) begin
      ext_enable           <= 1'b0;
      bank_select_register <= `JAI_RST_BANK;
      wacc                 <= `JAI_RST_WACC;
      flags                <= `JAI_RST_FLAGS;
      index_base           <= `JAI_RST_INDEX;
    end else begin
      if (apb_write) begin
        case (paddr)
          `JAI_OFS_CTRL: begin
            ext_enable           <= pwdata[`JAI_CTRL_EXT_BIT];
            bank_select_register <= pwdata[`JAI_CTRL_BANK_MSB:`JAI_CTRL_BANK_LSB];
          end
          `JAI_OFS_WACC: begin
            wacc <= pwdata[7:0];
          end
          `JAI_OFS_FLAGS: begin
            flags <= pwdata[4:0];
          end
          `JAI_OFS_INDEX: begin
            index_base <= pwdata[11:0];
          end
          default: begin
            index_base <= index_base;
          end
        endcase
      end
      if (exec_inc && cycle_end) begin
        if (!dest_reg) begin
          wacc <= inc_sum;
        end
        if (exec_plain) begin
          flags[`JAI_FLAG_C]      <= inc_carry;
          flags[`JAI_FLAG_HALF]   <= inc_half;
          flags[`JAI_FLAG_Z]      <= inc_zero;
          flags[`JAI_FLAG_EXCESS] <= inc_excess;
          flags[`JAI_FLAG_N]      <= inc_neg;
        end
      end
    end
  end

  // Data-memory strobes: read in the second phase, write in the last
  always @(posedge core_clk) begin
    if (rst) begin
      dmem_addr <= 12'h000;
      dmem_rd   <= 1'b0;
      dmem_wr   <= 1'b0;
    end else begin
      dmem_rd <= 1'b0;
      dmem_wr <= 1'b0;
      if ((phase == `JAI_Q_DECODE) && (state == ST_RUN) && is_inc_op(instr_word)) begin
        dmem_addr <= form_addr(instr_word[8], instr_word[7:0], bank_select_register,
                               ext_enable, index_base);
        dmem_rd   <= 1'b1;
      end
      if ((phase == `JAI_Q_PROCESS) && exec_inc && dest_reg) begin
        dmem_wr <= 1'b1;
      end
    end
  end

  // Instruction sequencing, program counter and no-op insertion
  always @(posedge core_clk) begin
    if (rst) begin
      state       <= ST_RUN;
      flush_left  <= 2'h0;
      ir          <= `JAI_NOP_WORD;
      pc          <= `JAI_RST_PC;
      fetch_flush <= 1'b0;
      last_cycles <= 2'h0;
      last_skip   <= 1'b0;
      last_jump   <= 1'b0;
      retired     <= {COUNT_W{1'b0}};
    end else begin
      fetch_flush <= 1'b0;
      if (phase == `JAI_Q_DECODE) begin
        // A discarded word is replaced by a no-op, never executed
        ir <= (state == ST_RUN) ? instr_word : `JAI_NOP_WORD;
      end
      if (cycle_end) begin
        case (state)
          ST_RUN: begin
            if (exec_jump) begin
              pc          <= jump_target;
              fetch_flush <= 1'b1;
              state       <= ST_FLUSH;
              flush_left  <= 2'h1;
              last_cycles <= 2'h2;
              last_skip   <= 1'b0;
              last_jump   <= 1'b1;
            end else if (skip_taken) begin
              fetch_flush <= 1'b1;
              state       <= ST_FLUSH;
              last_skip   <= 1'b1;
              last_jump   <= 1'b0;
              if (skip_two) begin
                pc          <= pc + `JAI_PC_STEP + `JAI_PC_STEP + `JAI_PC_STEP;
                flush_left  <= 2'h2;
                last_cycles <= 2'h3;
              end else begin
                pc          <= pc + `JAI_PC_STEP + `JAI_PC_STEP;
                flush_left  <= 2'h1;
                last_cycles <= 2'h2;
              end
            end else begin
              pc          <= pc + `JAI_PC_STEP;
              last_cycles <= 2'h1;
              last_skip   <= 1'b0;
              last_jump   <= 1'b0;
            end
            retired <= retired + {{(COUNT_W-1){1'b0}}, 1'b1};
          end
          ST_FLUSH: begin
            // Idle cycle: no fetch advance, no memory access, no flag change
            flush_left <= flush_left - 2'h1;
            if (flush_left == 2'h1) begin
              state <= ST_RUN;
            end
          end
          default: begin
            state      <= ST_RUN;
            flush_left <= 2'h0;
          end
        endcase
      end
    end
  end

endmodule // jai_exec

// *** tb/jai_exec_assertions.sv ***
// Port-level checks for the jump and increment executor
`timescale 1ns/1ps
module jai_exec_chk #(
  parameter COUNT_W = 8
) (
  input wire        core_clk,
  input wire        rst,
  input wire [15:0] instr_word,
  input wire [15:0] instr_next,
  input wire [20:0] pc,
  input wire        fetch_flush,
  input wire [1:0]  cycle_phase,
  input wire        dmem_rd,
  input wire [7:0]  dmem_rdata,
  input wire        dmem_wr,
  input wire [7:0]  dmem_wdata
);
  wire [7:0]  tgt_lo = instr_word[7:0];
  wire [11:0] tgt_hi = instr_next[11:0];
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // Flush cycles ignore their word; the fetch_flush gate excludes only the first, not the second after a two-word skip
  sequence jump_dec;
    cycle_phase == 2'h0 && !fetch_flush && instr_word[15:8] == 8'hEF;
  endsequence
  sequence jump_done;
    jump_dec ##3 cycle_phase == 2'h3;
  endsequence
  phase_step_a: assert property (!$past(rst) |->
    cycle_phase == $past(cycle_phase) + 2'h1) else $error("phase out of step");
  read_slot_a: assert property (dmem_rd |-> cycle_phase == 2'h1)
    else $error("read strobe outside read phase");
  write_slot_a: assert property (dmem_wr |-> cycle_phase == 2'h3 && $past(dmem_rd, 2))
    else $error("write strobe without read two clocks before");
  write_value_a: assert property (dmem_wr |-> dmem_wdata == $past(dmem_rdata) + 8'h01)
    else $error("written value is not read value plus one");
  flush_pulse_a: assert property (fetch_flush |-> cycle_phase == 2'h0 ##1 !fetch_flush)
    else $error("flush not a single decode-phase pulse");
  idle_quiet_a: assert property (fetch_flush |=> (!dmem_rd && !dmem_wr) [*3])
    else $error("memory access in discarded cycle");
  jump_target_a: assert property (jump_done |=>
    pc == {$past(tgt_hi), $past(tgt_lo, 4), 1'b0}) else $error("jump target wrong");
  jump_flush_a: assert property (jump_done |=> fetch_flush)
    else $error("jump without refill cycle");
  pc_moment_a: assert property ((!$past(rst) && pc != $past(pc)) |->
    $past(cycle_phase) == 2'h3) else $error("pc moved outside write phase");
endmodule // jai_exec_chk

bind jai_exec jai_exec_chk #(.COUNT_W(COUNT_W)) jai_exec_chk_i (
  .core_clk(core_clk),
  .rst(rst),
  .instr_word(instr_word),
  .instr_next(instr_next),
  .pc(pc),
  .fetch_flush(fetch_flush),
  .cycle_phase(cycle_phase),
  .dmem_rd(dmem_rd),
  .dmem_rdata(dmem_rdata),
  .dmem_wr(dmem_wr),
  .dmem_wdata(dmem_wdata)
);

// *** tb/jai_testbench.sv ***
// Self-checking bench for the jump and increment executor
`timescale 1ns/1ps
module testbench;
  reg         core_clk = 1'b0;
  reg         rst = 1'b1;
  reg  [11:0] paddr = 12'h0;
  reg         psel = 1'b0;
  reg         penable = 1'b0;
  reg         pwrite = 1'b0;
  reg  [31:0] pwdata = 32'h0;
  wire [31:0] prdata;
  wire        pready;
  wire        pslverr;
  wire [20:0] pc;
  wire        fetch_flush;
  wire [1:0]  cycle_phase;
  wire [11:0] dmem_addr;
  wire        dmem_rd;
  wire        dmem_wr;
  wire [7:0]  dmem_wdata;
  reg  [15:0] prog [0:255];
  reg  [7:0]  mem [0:4095];
  integer     errors = 0;
  integer     cmp_count = 0;
  integer     clk_n = 0;
  reg  [31:0] rd;
  reg         err;
  wire [15:0] instr_word = prog[pc[8:1]];
  wire [15:0] instr_next = prog[pc[8:1] + 8'h01];
  // Valid only in the process phase after the read strobe, inverted elsewhere to catch early sampling
  wire [7:0]  dmem_rdata = (cycle_phase == 2'h2) ? mem[dmem_addr] : ~mem[dmem_addr];

  always #2.5 core_clk = ~core_clk;

  always @(posedge core_clk) begin
    clk_n <= rst ? 0 : clk_n + 1;
    if (dmem_wr)
      mem[dmem_addr] <= dmem_wdata;
  end

  jai_exec #(
    .COUNT_W(8)
  ) jai_exec_i (
    .core_clk(core_clk),
    .rst(rst),
    .paddr(paddr),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .instr_word(instr_word),
    .instr_next(instr_next),
    .pc(pc),
    .fetch_flush(fetch_flush),
    .cycle_phase(cycle_phase),
    .dmem_addr(dmem_addr),
    .dmem_rd(dmem_rd),
    .dmem_rdata(dmem_rdata),
    .dmem_wr(dmem_wr),
    .dmem_wdata(dmem_wdata)
  );

  task conclude;
    begin
      $display("errors %0d comparisons %0d", errors, cmp_count);
      if (errors == 0 && cmp_count > 0)
        $display("Run complete: PASS");
      else
        $display("Run complete: FAIL");
      $finish;
    end
  endtask

  task chk(input [31:0] got, input [31:0] exp);
    begin
      cmp_count = cmp_count + 1;
      if (got !== exp) begin
        errors = errors + 1;
        $display("BAD %0t got %h expected %h", $time, got, exp);
      end
    end
  endtask

  // Lands just after the middle edge of instruction cycle c
  task at_cyc(input integer c);
    integer k;
    begin
      for (k = 0; k < 400 && clk_n < 4 * c + 2; k = k + 1) begin
        @(posedge core_clk);
        #1;
      end
      chk(clk_n, 4 * c + 2);
      if (k == 400)
        conclude;
    end
  endtask

  task apb(input w, input [11:0] a, input [31:0] d);
    integer k;
    begin
      @(posedge core_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      @(posedge core_clk);
      for (k = 0; k < 20 && pready !== 1'b1; k = k + 1)
        @(posedge core_clk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (k == 20) begin
        errors = errors + 1;
        conclude;
      end
    end
  endtask

  // Program of no-ops; execution starts at the edge this returns on
  task start;
    integer i;
    begin
      @(posedge core_clk);
      rst <= 1'b1;
      for (i = 0; i < 256; i = i + 1)
        prog[i] = 16'h0;
      repeat (2) @(posedge core_clk);
      rst <= 1'b0;
    end
  endtask

  task regs_case;
    begin
      start;
      apb(1'b0, 12'h000, 32'h0);
      chk(rd, 32'h0);
      apb(1'b1, 12'h000, 32'hFFFFFFFF);
      apb(1'b0, 12'h000, 32'h0);
      chk(rd, 32'hF01);
      apb(1'b1, 12'h00C, 32'hFFFFFFFF);
      chk(32'(err), 32'h1);
      apb(1'b0, 12'h01C, 32'h0);
      chk(32'(err), 32'h1);
      chk(rd, 32'h0);
    end
  endtask

  task jump_case;
    begin
      start;
      prog[6] = 16'hEF34;
      prog[7] = 16'hF567;
      apb(1'b1, 12'h008, 32'h15);
      at_cyc(7);
      chk(32'(pc), 32'h0ACE68);
      at_cyc(9);
      chk(32'(pc), 32'h0ACE6A);
      apb(1'b0, 12'h008, 32'h0);
      chk(rd, 32'h15);
    end
  endtask

  task inc_case(input d, input a, input ext, input [3:0] bank, input [7:0] f,
                 input [11:0] adr, input [7:0] v);
    reg [7:0] r;
    begin
      r = v + 8'h01;
      start;
      prog[6] = {6'h0A, d, a, f};
      mem[adr] = v;
      apb(1'b1, 12'h000, {20'h0, bank, 7'h0, ext});
      apb(1'b1, 12'h010, 32'h123);
      at_cyc(8);
      apb(1'b0, 12'h004, 32'h0);
      chk(rd, d ? 32'h0 : 32'(r));
      apb(1'b0, 12'h008, 32'h0);
      chk(rd, {27'h0, r[7], v == 8'h7F, r == 8'h0, v[3:0] == 4'hF, v == 8'hFF});
      chk(32'(mem[adr]), 32'(d ? r : v));
    end
  endtask

  task skip_case(input [5:0] op, input [7:0] v, input two, input [20:0] pc7);
    begin
      start;
      prog[6] = {op, 2'h3, 8'h10};
      prog[7] = two ? 16'hEF00 : 16'h0;
      prog[8] = two ? 16'hF000 : 16'h0;
      mem[12'h010] = v;
      apb(1'b1, 12'h008, 32'hA);
      at_cyc(7);
      chk(32'(pc), 32'(pc7));
      at_cyc(10);
      chk(32'(pc), 32'h14);
      apb(1'b0, 12'h008, 32'h0);
      chk(rd, 32'hA);
      chk({24'h0, mem[12'h010]}, {24'h0, v + 8'h01});
    end
  endtask

  initial begin
    repeat (16) @(posedge core_clk);
    regs_case;
    jump_case;
    inc_case(1'b1, 1'b1, 1'b0, 4'h3, 8'h10, 12'h310, 8'hFF);
    inc_case(1'b0, 1'b0, 1'b0, 4'h0, 8'h20, 12'h020, 8'h7F);
    inc_case(1'b1, 1'b0, 1'b0, 4'h0, 8'h80, 12'hF80, 8'h0E);
    inc_case(1'b1, 1'b0, 1'b1, 4'h0, 8'h5F, 12'h182, 8'h41);
    inc_case(1'b1, 1'b0, 1'b1, 4'h0, 8'h60, 12'hF60, 8'h00);
    inc_case(1'b1, 1'b1, 1'b1, 4'h5, 8'h5F, 12'h55F, 8'h0F);
    skip_case(6'h0F, 8'hFF, 1'b0, 21'h10);
    skip_case(6'h0F, 8'h00, 1'b0, 21'h0E);
    skip_case(6'h12, 8'h05, 1'b0, 21'h10);
    skip_case(6'h12, 8'hFF, 1'b0, 21'h0E);
    skip_case(6'h0F, 8'hFF, 1'b1, 21'h12);
    skip_case(6'h12, 8'h7F, 1'b1, 21'h12);
    conclude;
  end
endmodule // testbench
